// file: src/csc_map.svh
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH

`define CSC_CLK_MHZ        125
`define CSC_ALERT_US       256
`define CSC_ALERT_CYC      (`CSC_ALERT_US * `CSC_CLK_MHZ)
`define CSC_BLINK_HZ       1
`define CSC_BLINK_HALF_CYC ((`CSC_CLK_MHZ * 1000000) / (2 * `CSC_BLINK_HZ))

`define CSC_ILIM_500MA     5'h04
`define CSC_ILIM_2A4       5'h17

`define CSC_OFF_CTRL       5'h00
`define CSC_OFF_ILIM       5'h04
`define CSC_OFF_STATUS     5'h08
`define CSC_OFF_INT_STS    5'h0C
`define CSC_OFF_INT_MASK   5'h10

`define CSC_CTRL_CFG       0
`define CSC_CTRL_IND       3:2
`define CSC_CTRL_DP        5:4
`define CSC_CTRL_DM        7:6
`define CSC_CTRL_RST       8'h01
`define CSC_IND_ON         2'h0
`define CSC_ILIM_FLD       4:0
`define CSC_ILIM_OVR       8

`define CSC_IRQ_CHG        0
`define CSC_IRQ_FLT        1
`define CSC_IRQ_PG         2
`define CSC_IRQ_W          3

`endif

// file: src/csc_pkg.sv
package csc_pkg;

  typedef enum logic [1:0] {
    CSC_ST_IDLE = 2'h0,
    CSC_ST_CHG  = 2'h1,
    CSC_ST_FLT  = 2'h3
  } csc_stat_t;

endpackage : csc_pkg

// file: src/csc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module csc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second one.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : csc_sync
`default_nettype wire

// file: src/csc_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module csc_pulse #(
  parameter int unsigned LEN = 2
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic start_i,
  output var  logic active_o
);

  localparam int CW = $clog2(LEN + 1);

  logic [CW-1:0] cnt_r;

  // A new start restarts the full length, so a late event still gets a whole pulse.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r    <= '0;
      active_o <= 1'b0;
    end else if (start_i) begin
      cnt_r    <= CW'(LEN);
      active_o <= 1'b1;
    end else if (cnt_r != '0) begin
      cnt_r    <= cnt_r - 1'b1;
      active_o <= (cnt_r != CW'(1));
    end
  end

endmodule : csc_pulse
`default_nettype wire

// file: src/csc_top.sv
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "csc_map.svh"
// What this block does
// - Source-select high defaults input limit to 500mA, low defaults to 2.4A.
// - A host-written five-bit limit field replaces the pin-selected default.
// - Input-good drives low only with input in window and limit above 30mA.
// - Charge-status indicator is held low while a charge cycle runs.
// - Charge-status indicator is released when charging is done or asleep.
// - A fault suspension blinks the charge-status indicator at 1Hz, 50% duty.
// - A two-bit indicator-function field lets software disable the indicator.
// - Each status update or fault drives a 256us low pulse on host alert.
// - Charging is enabled only with the config bit set and enable pin low.
// - Each USB data line level follows its own two-bit level-select field.
// - The host alert pulse starts at once, with no host access needed.
module csc_top
  import csc_pkg::*;
#(
  parameter int unsigned ALERT_CYC = `CSC_ALERT_CYC,
  parameter int unsigned HALF_CYC  = `CSC_BLINK_HALF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output var  logic [31:0] avs_readdata_o,
  output var  logic        avs_waitrequest_o,
  output var  logic        irq_o,
  input  wire logic        source_select_i,
  input  wire logic        charge_enable_n_pin_i,
  input  wire logic        vin_above_undervoltage_lockout_i,
  input  wire logic        vin_below_ovp_i,
  input  wire logic        vin_above_sleep_i,
  input  wire logic        ilim_above_30ma_i,
  input  wire logic        charging_i,
  input  wire logic        charge_done_i,
  input  wire logic        sleep_mode_i,
  input  wire logic        fault_i,
  output var  logic [4:0]  input_current_limit_field_o,
  output var  logic        charge_enable_o,
  output var  logic [1:0]  dplus_level_select_o,
  output var  logic [1:0]  dminus_level_select_o,
  output var  logic        input_good_n_oe_o,
  output var  logic        charge_status_oe_o,
  output var  logic        host_alert_n_oe_o
);

  localparam int BW = $clog2(HALF_CYC);

  function automatic logic csc_sel(input logic [4:0] addr, input logic [4:0] off);
    csc_sel = (addr == off);
  endfunction : csc_sel

  logic [5:0]            pin_s;
  logic                  src_sel;
  logic                  nce_s;
  logic                  pg_nxt;
  logic                  pg_r;
  logic [7:0]            ctrl_r;
  logic [4:0]            ilim_r;
  logic                  ovr_r;
  logic [`CSC_IRQ_W-1:0] sts_r;
  logic [`CSC_IRQ_W-1:0] mask_r;
  logic [`CSC_IRQ_W-1:0] ev;
  logic [`CSC_IRQ_W-1:0] w1c;
  logic                  wr_en;
  logic                  ctrl_we;
  logic                  ilim_we;
  logic                  clr_we;
  logic                  mask_we;
  logic [31:0]           rd_mux;
  csc_stat_t             st_r;
  csc_stat_t             st_nxt;
  logic                  stat_drive;
  logic                  ind_on;
  logic [BW-1:0]         blk_cnt_r;
  logic                  blink_r;
  logic                  alert_start;

  // The six source, enable and input-good pins arrive from outside the clock domain and pass two flops first.
  // The enable pin enters inverted, so the cleared synchroniser holds charging off until the pin is seen.
  csc_sync #(
    .W (6)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({source_select_i, ~charge_enable_n_pin_i, vin_above_undervoltage_lockout_i,
                 vin_below_ovp_i, vin_above_sleep_i, ilim_above_30ma_i}),
    .q_o       (pin_s)
  );

  assign src_sel = pin_s[5];
  assign nce_s   = ~pin_s[4];
  assign pg_nxt  = &pin_s[3:0];
  assign ind_on  = (ctrl_r[`CSC_CTRL_IND] == `CSC_IND_ON);

  // Register bus: one wait cycle, then the access completes.
  assign wr_en   = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  assign ctrl_we = wr_en & csc_sel(avs_address_i, `CSC_OFF_CTRL);
  assign ilim_we = wr_en & csc_sel(avs_address_i, `CSC_OFF_ILIM);
  assign clr_we  = wr_en & csc_sel(avs_address_i, `CSC_OFF_INT_STS);
  assign mask_we = wr_en & csc_sel(avs_address_i, `CSC_OFF_INT_MASK);
  assign w1c     = clr_we ? avs_writedata_i[`CSC_IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
    end
  end

  always_comb begin
    rd_mux = '0;
    if (csc_sel(avs_address_i, `CSC_OFF_CTRL)) begin
      rd_mux[7:0] = ctrl_r;
    end else if (csc_sel(avs_address_i, `CSC_OFF_ILIM)) begin
      rd_mux[`CSC_ILIM_FLD] = ilim_r;
      rd_mux[`CSC_ILIM_OVR] = ovr_r;
    end else if (csc_sel(avs_address_i, `CSC_OFF_STATUS)) begin
      rd_mux[5:0] = {host_alert_n_oe_o, st_r, pg_r, charge_enable_o, src_sel};
    end else if (csc_sel(avs_address_i, `CSC_OFF_INT_STS)) begin
      rd_mux[`CSC_IRQ_W-1:0] = sts_r;
    end else if (csc_sel(avs_address_i, `CSC_OFF_INT_MASK)) begin
      rd_mux[`CSC_IRQ_W-1:0] = mask_r;
    end
  end

  // Data is loaded in the wait cycle so it already stands when waitrequest drops.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i & avs_waitrequest_o) begin
      avs_readdata_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= `CSC_CTRL_RST;
    end else if (ctrl_we) begin
      ctrl_r <= avs_writedata_i[7:0];
    end
  end

  // A host write latches the override for good; only reset returns to the pin default.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ilim_r <= '0;
      ovr_r  <= 1'b0;
    end else if (ilim_we) begin
      ilim_r <= avs_writedata_i[`CSC_ILIM_FLD];
      ovr_r  <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      input_current_limit_field_o <= `CSC_ILIM_2A4;
    end else if (ovr_r) begin
      input_current_limit_field_o <= ilim_r;
    end else begin
      input_current_limit_field_o <= src_sel ? `CSC_ILIM_500MA : `CSC_ILIM_2A4;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      charge_enable_o <= 1'b0;
    end else begin
      charge_enable_o <= ctrl_r[`CSC_CTRL_CFG] & ~nce_s;
    end
  end

  assign dplus_level_select_o  = ctrl_r[`CSC_CTRL_DP];
  assign dminus_level_select_o = ctrl_r[`CSC_CTRL_DM];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pg_r              <= 1'b0;
      input_good_n_oe_o <= 1'b0;
    end else begin
      pg_r              <= pg_nxt;
      input_good_n_oe_o <= pg_nxt;
    end
  end

  // A fault outranks an active charge; done or sleep releases the indicator.
  always_comb begin
    if (fault_i) begin
      st_nxt = CSC_ST_FLT;
    end else if (charging_i & ~charge_done_i & ~sleep_mode_i) begin
      st_nxt = CSC_ST_CHG;
    end else begin
      st_nxt = CSC_ST_IDLE;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= CSC_ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The blink starts low on fault entry so the host sees the first edge at once.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      blk_cnt_r <= '0;
      blink_r   <= 1'b1;
    end else if (st_r != CSC_ST_FLT) begin
      blk_cnt_r <= '0;
      blink_r   <= 1'b1;
    end else if (blk_cnt_r == BW'(HALF_CYC - 1)) begin
      blk_cnt_r <= '0;
      blink_r   <= ~blink_r;
    end else begin
      blk_cnt_r <= blk_cnt_r + 1'b1;
    end
  end

  always_comb begin
    unique case (st_r)
      CSC_ST_IDLE: stat_drive = 1'b0;
      CSC_ST_CHG:  stat_drive = 1'b1;
      CSC_ST_FLT:  stat_drive = blink_r;
      default:     stat_drive = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      charge_status_oe_o <= 1'b0;
    end else begin
      charge_status_oe_o <= ind_on & stat_drive;
    end
  end

  assign ev[`CSC_IRQ_CHG] = (st_nxt != st_r);
  assign ev[`CSC_IRQ_FLT] = (st_nxt == CSC_ST_FLT) & (st_r != CSC_ST_FLT);
  assign ev[`CSC_IRQ_PG]  = (pg_nxt != pg_r);
  // The alert ignores the mask; the mask only gates the bus interrupt.
  assign alert_start      = |ev;

  csc_pulse #(
    .LEN (ALERT_CYC)
  ) u_alert (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (alert_start),
    .active_o  (host_alert_n_oe_o)
  );

  // A new event in the clearing cycle survives, because the set term is applied last.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sts_r <= '0;
    end else begin
      sts_r <= (sts_r & ~w1c) | ev;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mask_r <= '0;
    end else if (mask_we) begin
      mask_r <= avs_writedata_i[`CSC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(sts_r & mask_r);
    end
  end

  // Checking helpers.
  int unsigned alert_len_q;
  logic        pg_pins;

  assign pg_pins = vin_above_undervoltage_lockout_i & vin_below_ovp_i & vin_above_sleep_i & ilim_above_30ma_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alert_len_q <= 0;
    end else if (alert_start) begin
      alert_len_q <= 1;
    end else if (host_alert_n_oe_o) begin
      alert_len_q <= alert_len_q + 1;
    end else begin
      alert_len_q <= 0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_bus_req;
    (avs_read_i | avs_write_i) && avs_waitrequest_o;
  endsequence

  sequence s_fault_entry;
    ev[`CSC_IRQ_FLT] ##1 1'b1;
  endsequence

  sequence s_stat_in_fault;
    st_r == CSC_ST_FLT && $past(st_r) == CSC_ST_FLT;
  endsequence

  property p_bus_ack;
    s_bus_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("Bus access not answered after one wait cycle.");

  property p_ilim_default;
    !ovr_r && $stable(src_sel) |=> input_current_limit_field_o == ($past(src_sel) ? `CSC_ILIM_500MA : `CSC_ILIM_2A4);
  endproperty
  a_ilim_default: assert property (p_ilim_default) else $error("Default limit does not follow source select.");

  property p_ilim_override;
    ilim_we |=> ##1 input_current_limit_field_o == $past(avs_writedata_i[4:0], 2);
  endproperty
  a_ilim_override: assert property (p_ilim_override) else $error("Written limit not applied.");

  property p_input_good;
    !$past(sys_rst_i, 3) |-> input_good_n_oe_o == $past(pg_pins, 3);
  endproperty
  a_input_good: assert property (p_input_good) else $error("Input good does not match input window.");

  property p_stat_charge;
    st_r == CSC_ST_CHG && ind_on |=> charge_status_oe_o;
  endproperty
  a_stat_charge: assert property (p_stat_charge) else $error("Status not held low while charging.");

  property p_stat_release;
    (charge_done_i || sleep_mode_i) && !fault_i |-> ##2 !charge_status_oe_o;
  endproperty
  a_stat_release: assert property (p_stat_release) else $error("Status not released when done or asleep.");

  property p_blink_period;
    s_stat_in_fault ##0 $changed(blink_r) |-> $past(blk_cnt_r) == BW'(HALF_CYC - 1);
  endproperty
  a_blink_period: assert property (p_blink_period) else $error("Fault blink half period is wrong.");

  property p_ind_off;
    !ind_on |=> !charge_status_oe_o;
  endproperty
  a_ind_off: assert property (p_ind_off) else $error("Disabled indicator still driven.");

  property p_alert_len;
    $fell(host_alert_n_oe_o) |-> $past(alert_len_q) == ALERT_CYC;
  endproperty
  a_alert_len: assert property (p_alert_len) else $error("Host alert pulse length is wrong.");

  property p_chg_en;
    $rose(charge_enable_o) |-> $past(ctrl_r[`CSC_CTRL_CFG]) && !$past(charge_enable_n_pin_i, 3);
  endproperty
  a_chg_en: assert property (p_chg_en) else $error("Charging enabled without both conditions.");

  property p_dlevel;
    ctrl_we |=> dplus_level_select_o == $past(avs_writedata_i[5:4])
             && dminus_level_select_o == $past(avs_writedata_i[7:6]);
  endproperty
  a_dlevel: assert property (p_dlevel) else $error("Data line level select not applied.");

  property p_alert_fast;
    s_fault_entry |-> host_alert_n_oe_o;
  endproperty
  a_alert_fast: assert property (p_alert_fast) else $error("Host alert late after fault.");

  property p_irq;
    |(sts_r & mask_r) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("Unmasked status did not raise interrupt.");

endmodule : csc_top
`default_nettype wire

// file: bench/csc_host.sv
`timescale 1ns/1ps
`default_nettype none
module csc_host (
  input  wire logic        clk_i,
  input  wire logic [31:0] avs_readdata_i,
  input  wire logic        avs_waitrequest_i,
  input  wire logic        input_good_n_oe_i,
  input  wire logic        charge_status_oe_i,
  input  wire logic        host_alert_n_oe_i,
  output var  logic [4:0]  avs_address_o,
  output var  logic        avs_read_o,
  output var  logic        avs_write_o,
  output var  logic [31:0] avs_writedata_o,
  output var  logic [3:0]  avs_byteenable_o,
  output var  logic        input_good_n_o,
  output var  logic        charge_status_o,
  output var  logic        host_alert_n_o,
  output var  logic        timed_out_o
);
  // Released open-drain pins read high through the board pull-ups.
  assign input_good_n_o  = input_good_n_oe_i ? 1'b0 : 1'b1;
  assign charge_status_o = charge_status_oe_i ? 1'b0 : 1'b1;
  assign host_alert_n_o  = host_alert_n_oe_i ? 1'b0 : 1'b1;

  initial begin
    avs_address_o    = 5'h00;
    avs_read_o       = 1'b0;
    avs_write_o      = 1'b0;
    avs_writedata_o  = 32'h0;
    avs_byteenable_o = 4'h0;
    timed_out_o      = 1'b0;
  end

  task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_o    <= a;
    avs_read_o       <= ~wr;
    avs_write_o      <= wr;
    avs_writedata_o  <= d;
    avs_byteenable_o <= be;
    @(posedge clk_i);
    while (avs_waitrequest_i !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    q = avs_readdata_i;
    if (n >= 50) timed_out_o = 1'b1;
    avs_read_o      <= 1'b0;
    avs_write_o     <= 1'b0;
    // Idle data is scrambled so a slave that latches it off-cycle shows up.
    avs_writedata_o <= ~d;
  endtask : access
endmodule : csc_host
`default_nettype wire

// file: bench/csc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module csc_top_tb;
  localparam int unsigned ALERT = 20;
  localparam int unsigned HALF  = 8;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        src       = 1'b0;
  logic        ce_n      = 1'b0;
  logic [3:0]  vin       = 4'hF;
  logic [3:0]  chg       = 4'h0;
  logic [4:0]  adr, lim;
  logic [31:0] wd, rdat, q;
  logic [3:0]  be;
  logic [1:0]  dp, dm;
  logic        rd, wr, wt, irq, cen, pg_oe, st_oe, al_oe, pg_n, st, al_n, to;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          n;

  always #4 clk_i = ~clk_i;

  csc_top #(.ALERT_CYC(ALERT), .HALF_CYC(HALF)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .irq_o(irq), .source_select_i(src), .charge_enable_n_pin_i(ce_n), .vin_above_undervoltage_lockout_i(vin[0]),
    .vin_below_ovp_i(vin[1]), .vin_above_sleep_i(vin[2]), .ilim_above_30ma_i(vin[3]),
    .charging_i(chg[0]), .charge_done_i(chg[1]), .sleep_mode_i(chg[2]), .fault_i(chg[3]),
    .input_current_limit_field_o(lim), .charge_enable_o(cen), .dplus_level_select_o(dp),
    .dminus_level_select_o(dm), .input_good_n_oe_o(pg_oe), .charge_status_oe_o(st_oe),
    .host_alert_n_oe_o(al_oe));

  csc_host host (
    .clk_i(clk_i), .avs_readdata_i(rdat), .avs_waitrequest_i(wt), .input_good_n_oe_i(pg_oe),
    .charge_status_oe_i(st_oe), .host_alert_n_oe_i(al_oe), .avs_address_o(adr), .avs_read_o(rd),
    .avs_write_o(wr), .avs_writedata_o(wd), .avs_byteenable_o(be), .input_good_n_o(pg_n),
    .charge_status_o(st), .host_alert_n_o(al_n), .timed_out_o(to));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
  endtask : step

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    host.access(1'b1, a, d, 4'hF, q);
  endtask : wreg

  task automatic rreg(input logic [4:0] a);
    host.access(1'b0, a, 32'h0, 4'hF, q);
  endtask : rreg

  // Counts cycles that a pin enable holds lvl, after waiting for it to get there.
  task automatic run_len(input logic sel, input logic lvl, output int k);
    int g;
    g = 0;
    k = 0;
    while ((sel ? st_oe : al_oe) !== lvl && g < 200) begin
      g++;
      @(posedge clk_i);
    end
    while ((sel ? st_oe : al_oe) === lvl && k < 200) begin
      k++;
      @(posedge clk_i);
    end
  endtask : run_len

  task automatic t_reset();
    chk("lim_rst", lim, 32'h17);
    chk("alert_pin_rst", al_n, 32'h1);
    step(1);
    sys_rst_i <= 1'b0;
    rreg(5'h00);
    chk("ctrl_rst", q, 32'h1);
    wreg(5'h14, 32'hFF);
    rreg(5'h14);
    chk("unmapped", q, 32'h0);
    rreg(5'h10);
    chk("mask_rst", q, 32'h0);
  endtask : t_reset

  task automatic t_limit_default();
    chk("lim_low", lim, 32'h17);
    src <= 1'b1;
    step(4);
    chk("lim_high", lim, 32'h04);
  endtask : t_limit_default

  task automatic t_input_good();
    chk("pg_oe", pg_oe, 32'h1);
    chk("pg_pin", pg_n, 32'h0);
    for (int i = 0; i < 4; i++) begin
      vin <= ~(4'h1 << i);
      step(4);
      chk("pg_off", pg_oe, 32'h0);
      vin <= 4'hF;
      step(4);
      chk("pg_on", pg_oe, 32'h1);
    end
  endtask : t_input_good

  task automatic t_charge_en();
    chk("cen_on", cen, 32'h1);
    ce_n <= 1'b1;
    step(4);
    chk("cen_pin", cen, 32'h0);
    ce_n <= 1'b0;
    wreg(5'h00, 32'h0);
    step(2);
    chk("cen_cfg", cen, 32'h0);
    wreg(5'h00, 32'h1);
  endtask : t_charge_en

  task automatic t_usb_levels();
    for (int v = 0; v < 4; v++) begin
      wreg(5'h00, 32'((3 - v) * 64 + v * 16 + 1));
      step(2);
      chk("dplus", dp, 32'(v));
      chk("dminus", dm, 32'(3 - v));
    end
    wreg(5'h00, 32'h1);
  endtask : t_usb_levels

  task automatic t_status_pin();
    chg <= 4'h1;
    step(3);
    chk("stat_chg", st_oe, 32'h1);
    chk("stat_pin", st, 32'h0);
    for (int m = 1; m < 4; m++) begin
      wreg(5'h00, 32'(m * 4 + 1));
      step(3);
      chk("stat_off", st_oe, 32'h0);
    end
    wreg(5'h00, 32'h1);
    step(3);
    chk("stat_back", st_oe, 32'h1);
    chg <= 4'h3;
    step(3);
    chk("stat_done", st_oe, 32'h0);
    chg <= 4'h5;
    step(3);
    chk("stat_sleep", st_oe, 32'h0);
    chg <= 4'h0;
  endtask : t_status_pin

  task automatic t_fault_alert();
    step(ALERT + 5);
    wreg(5'h0C, 32'h7);
    rreg(5'h0C);
    chk("sts_clr", q, 32'h0);
    wreg(5'h10, 32'h2);
    step(2);
    chk("irq_idle", irq, 32'h0);
    chg <= 4'h8;
    run_len(1'b0, 1'b1, n);
    chk("alert_len", n, ALERT);
    run_len(1'b1, 1'b1, n);
    run_len(1'b1, 1'b0, n);
    chk("blink_low", n, HALF);
    run_len(1'b1, 1'b1, n);
    chk("blink_high", n, HALF);
    chk("irq_set", irq, 32'h1);
    rreg(5'h0C);
    chk("sts_flt", q, 32'h3);
    rreg(5'h08);
    chk("state_flt", q[4:3], 32'h3);
    wreg(5'h0C, 32'h2);
    step(3);
    chk("irq_clr", irq, 32'h0);
    rreg(5'h0C);
    chk("sts_w1c", q, 32'h1);
    wreg(5'h10, 32'h1);
    step(3);
    chk("irq_mask", irq, 32'h1);
    wreg(5'h0C, 32'h1);
    step(3);
    chk("irq_off", irq, 32'h0);
    chg <= 4'h0;
  endtask : t_fault_alert

  task automatic t_override();
    host.access(1'b1, 5'h04, 32'h0A, 4'hE, q);
    step(3);
    chk("lim_be", lim, 32'h04);
    wreg(5'h04, 32'h0A);
    step(3);
    chk("lim_ovr", lim, 32'h0A);
    rreg(5'h04);
    chk("ilim_rd", q, 32'h10A);
    src <= 1'b0;
    step(4);
    chk("lim_hold", lim, 32'h0A);
  endtask : t_override

  task automatic wrap_up();
    if (to === 1'b1) bad_count++;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    step(11);
    t_reset();
    t_limit_default();
    t_input_good();
    t_charge_en();
    t_usb_levels();
    t_status_pin();
    t_fault_alert();
    t_override();
    wrap_up();
  end

  // The scenarios need well under a thousand cycles, so this is ample margin.
  initial begin
    #40000;
    bad_count++;
    wrap_up();
  end
endmodule : csc_top_tb
`default_nettype wire
